/* File: rtl/oss_pkg.sv */
// Package of constants and codes for the output setpoint sequencer.
package oss_pkg;
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1;
  localparam int          SLOT_COUNT  = 9;
  localparam int          VOLT_MODES  = 2;
  localparam int          TC_MODES    = 12;
  localparam int          RTD_STD     = 11;
  localparam int          RTD_CUSTOM  = 5;
  localparam int          MODE_COUNT  = VOLT_MODES + TC_MODES + RTD_STD + RTD_CUSTOM;
  localparam int          MODE_W      = 5;
  localparam int          VALUE_W     = 24;
  localparam int          KEY_W       = 5;
  localparam logic [8:0]  DWELL_MIN   = 9'h005;
  localparam logic [8:0]  DWELL_MAX   = 9'h1F4;
  localparam logic [3:0]  IDX_FIRST   = 4'h1;
  localparam logic [3:0]  IDX_LAST    = 4'h9;
  localparam logic [4:0]  KEY_ENTER   = 5'h0A;
  localparam logic [4:0]  KEY_HOLD    = 5'h0B;
  localparam logic [4:0]  KEY_AUTO    = 5'h03;
  localparam logic [4:0]  KEY_STORE   = 5'h01;
  localparam logic [4:0]  KEY_RECALL  = 5'h02;
  typedef enum logic [5:0] {
    OSS_IDLE   = 6'b000001,
    OSS_STORE  = 6'b000010,
    OSS_RECALL = 6'b000100,
    OSS_END    = 6'b001000,
    OSS_DWELL  = 6'b010000,
    OSS_RUN    = 6'b100000
  } oss_state_e;
endpackage

/* File: rtl/oss_sequencer.sv */
// Setpoint store, recall and automatic up-down cycle engine.
`timescale 1ns/1ps
module oss_sequencer
  import oss_pkg::*;
(
  input  wire logic               core_clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               key_valid_in,
  input  wire logic [KEY_W-1:0]   key_code_in,
  input  wire logic               key_shift_in,
  input  wire logic [MODE_W-1:0]  out_mode_in,
  input  wire logic [VALUE_W-1:0] entered_value_in,
  output logic [VALUE_W-1:0]      setpoint_value_out,
  output logic                    setpoint_load_out,
  output logic [3:0]              active_index_out,
  output logic                    auto_cycle_function_out,
  output logic                    recall_index_prompt_out
);

  oss_state_e               state;
  oss_state_e               next_state;
  logic [VALUE_W-1:0]       bank [MODE_COUNT*SLOT_COUNT];
  logic [3:0]               end_idx;
  logic [3:0]               cur_idx;
  logic                     going_up;
  logic [8:0]               dwell;
  logic [8:0]               dwell_acc;
  logic [8:0]               sec_count;
  logic [24:0]              tick_div;
  logic                     tick;

  // Keys are clocked with the core, so no synchroniser is needed here.
  function automatic logic is_digit(input logic [KEY_W-1:0] k);
    return (k >= 5'h01) && (k <= 5'h09) && !key_shift_in;
  endfunction

  function automatic int slot_addr(input logic [MODE_W-1:0] m, input logic [3:0] i);
    return int'(m) * SLOT_COUNT + int'(i) - 1;
  endfunction

  wire       digit_key  = key_valid_in && is_digit(key_code_in);
  wire [3:0] digit_val  = key_code_in[3:0];
  wire       mode_ok    = int'(out_mode_in) < MODE_COUNT;
  wire       shift_cmd  = key_valid_in && key_shift_in;
  wire       dec_key    = key_valid_in && !key_shift_in && key_code_in <= 5'h09;
  wire       stop_key   = key_valid_in && !(key_code_in == KEY_HOLD && !key_shift_in);
  wire       dwell_done = tick && (sec_count + 9'h001 >= dwell);
  wire       at_top     = (cur_idx >= end_idx);
  wire       at_bottom  = (cur_idx == IDX_FIRST);
  wire       turn_down  = going_up && at_top;
  wire       turn_up    = !going_up && at_bottom;
  wire       next_up    = (turn_down || turn_up) ? !going_up : going_up;
  wire [3:0] step_idx   = (end_idx == IDX_FIRST) ? IDX_FIRST :
                          next_up ? cur_idx + 4'h1 : cur_idx - 4'h1;
  wire [13:0] dwell_wide = 14'(dwell_acc) * 14'h000A + 14'(digit_val);
  // Saturate so that extra digits can never wrap back into the legal dwell range.
  wire [8:0] dwell_in   = (dwell_wide > 14'(DWELL_MAX)) ? 9'h1FF : dwell_wide[8:0];
  wire       dwell_ok   = dwell_acc >= DWELL_MIN && dwell_acc <= DWELL_MAX;

  always_comb begin
    next_state = state;
    unique case (state)
      OSS_IDLE: begin
        if (shift_cmd && key_code_in == KEY_STORE) next_state = OSS_STORE;
        else if (shift_cmd && key_code_in == KEY_RECALL) next_state = OSS_RECALL;
        else if (shift_cmd && key_code_in == KEY_AUTO) next_state = OSS_END;
      end
      OSS_STORE, OSS_RECALL: begin
        if (key_valid_in) next_state = OSS_IDLE;
      end
      OSS_END: begin
        if (digit_key) next_state = OSS_DWELL;
        else if (key_valid_in) next_state = OSS_IDLE;
      end
      OSS_DWELL: begin
        if (key_valid_in && !key_shift_in && key_code_in == KEY_ENTER)
          next_state = (dwell_ok && mode_ok) ? OSS_RUN : OSS_IDLE;
        else if (key_valid_in && !dec_key) next_state = OSS_IDLE;
      end
      OSS_RUN: begin
        if (stop_key) next_state = OSS_IDLE;
      end
      default: next_state = OSS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_div <= 25'h0000000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_div == 25'(TICK_CYCLES - 1));
      tick_div <= (tick_div == 25'(TICK_CYCLES - 1)) ? 25'h0000000 : tick_div + 25'h0000001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (state == OSS_STORE && digit_key && mode_ok)
      bank[slot_addr(out_mode_in, digit_val)] <= entered_value_in;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state                   <= OSS_IDLE;
      end_idx                 <= 4'h1;
      cur_idx                 <= 4'h1;
      going_up                <= 1'b1;
      dwell                   <= DWELL_MIN;
      dwell_acc               <= 9'h000;
      sec_count               <= 9'h000;
      setpoint_value_out      <= '0;
      setpoint_load_out       <= 1'b0;
      active_index_out        <= 4'h0;
      auto_cycle_function_out <= 1'b0;
      recall_index_prompt_out <= 1'b0;
    end else begin
      state                   <= next_state;
      setpoint_load_out       <= 1'b0;
      auto_cycle_function_out <= (next_state == OSS_RUN);
      recall_index_prompt_out <= (next_state == OSS_RECALL);
      if (state == OSS_RECALL && digit_key && mode_ok) begin
        setpoint_value_out <= bank[slot_addr(out_mode_in, digit_val)];
        setpoint_load_out  <= 1'b1;
        active_index_out   <= digit_val;
      end
      if (state == OSS_END && digit_key) begin
        end_idx   <= digit_val;
        dwell_acc <= 9'h000;
      end
      if (state == OSS_DWELL && dec_key) dwell_acc <= (dwell_acc > DWELL_MAX) ? dwell_acc : dwell_in;
      if (state == OSS_DWELL && next_state == OSS_RUN) begin
        dwell              <= dwell_acc;
        cur_idx            <= IDX_FIRST;
        going_up           <= 1'b1;
        sec_count          <= 9'h000;
        setpoint_value_out <= bank[slot_addr(out_mode_in, IDX_FIRST)];
        setpoint_load_out  <= 1'b1;
        active_index_out   <= IDX_FIRST;
      end
      if (state == OSS_RUN && next_state == OSS_RUN && tick) begin
        if (dwell_done) begin
          sec_count          <= 9'h000;
          cur_idx            <= step_idx;
          going_up           <= next_up;
          setpoint_value_out <= bank[slot_addr(out_mode_in, step_idx)];
          setpoint_load_out  <= (step_idx != cur_idx);
          active_index_out   <= step_idx;
        end else begin
          sec_count <= sec_count + 9'h001;
        end
      end
    end
  end

  sequence run_s;
    state == OSS_RUN;
  endsequence

  sequence store_pick_s;
    state == OSS_STORE && digit_key && mode_ok;
  endsequence

  sequence recall_pick_s;
    state == OSS_RECALL && digit_key && mode_ok;
  endsequence

  sequence start_s;
    state == OSS_DWELL && next_state == OSS_RUN;
  endsequence

  sequence enter_s;
    state == OSS_DWELL && key_valid_in && !key_shift_in && key_code_in == KEY_ENTER;
  endsequence

  sequence step_s;
    run_s ##0 (next_state == OSS_RUN && dwell_done);
  endsequence

  store_no_load_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_STORE |=> !setpoint_load_out)
    else $error("Store must not drive the output.");
  store_write_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    store_pick_s |=> bank[slot_addr($past(out_mode_in), $past(digit_val))]
      == $past(entered_value_in))
    else $error("Store did not capture the entered value.");
  store_exit_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_STORE && key_valid_in |=> state == OSS_IDLE)
    else $error("Store prompt took more than one key.");
  recall_load_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    recall_pick_s |=> setpoint_load_out && active_index_out == $past(digit_val))
    else $error("Recall did not load the chosen slot.");
  recall_value_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    recall_pick_s |=> setpoint_value_out == $past(bank[slot_addr(out_mode_in, digit_val)]))
    else $error("Recall drove the wrong value.");
  recall_prompt_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_RECALL |-> recall_index_prompt_out)
    else $error("Recall prompt missing.");
  recall_shift_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_RECALL && key_valid_in && key_shift_in |=> !setpoint_load_out)
    else $error("Shifted key recalled a slot.");
  recall_exit_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_RECALL && key_valid_in |=> state == OSS_IDLE && !recall_index_prompt_out)
    else $error("Recall prompt did not close.");
  auto_entry_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_IDLE && shift_cmd && key_code_in == KEY_AUTO |=> state == OSS_END)
    else $error("Shift three did not open the ending prompt.");
  end_index_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_END && digit_key |=> end_idx == $past(digit_val))
    else $error("Ending index not taken.");
  end_abort_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    state == OSS_END && key_valid_in && !digit_key |=> state == OSS_IDLE)
    else $error("Non-digit key did not abort the ending prompt.");
  enter_bad_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    enter_s ##0 !dwell_ok |=> state == OSS_IDLE && !auto_cycle_function_out)
    else $error("Illegal dwell started a cycle.");
  enter_good_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    enter_s ##0 (dwell_ok && mode_ok) |=>
      run_s ##0 (auto_cycle_function_out && setpoint_load_out))
    else $error("Legal dwell did not start a cycle.");
  dwell_take_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    start_s |=> dwell == $past(dwell_acc))
    else $error("Dwell not taken at cycle start.");
  dwell_range_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s |-> dwell >= DWELL_MIN && dwell <= DWELL_MAX && sec_count < dwell)
    else $error("Dwell outside limits.");
  dwell_hold_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s ##0 !dwell_done |=> $stable(setpoint_value_out) && $stable(active_index_out))
    else $error("Setpoint changed before the dwell ended.");
  cycle_start_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    start_s |=> active_index_out == IDX_FIRST && going_up)
    else $error("Cycle did not start at one.");
  start_value_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    start_s |=> setpoint_value_out == $past(bank[slot_addr(out_mode_in, IDX_FIRST)]))
    else $error("Cycle start drove the wrong value.");
  climb_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    step_s ##0 (going_up && !at_top) |=> cur_idx == $past(cur_idx) + 4'h1)
    else $error("Cycle did not climb by one.");
  index_range_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s |-> cur_idx >= IDX_FIRST && cur_idx <= end_idx)
    else $error("Cycle index out of range.");
  turn_down_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    step_s ##0 (turn_down && end_idx != IDX_FIRST) |=>
      !going_up && cur_idx + 4'h1 == $past(cur_idx))
    else $error("Cycle did not turn down at the top.");
  turn_up_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    step_s ##0 (turn_up && end_idx != IDX_FIRST) |=> going_up && cur_idx == IDX_FIRST + 4'h1)
    else $error("Cycle did not turn up at the bottom.");
  hold_key_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s and key_valid_in && !key_shift_in && key_code_in == KEY_HOLD |=> run_s)
    else $error("Designated key stopped the cycle.");
  hold_steady_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s ##0 (key_valid_in && !key_shift_in && key_code_in == KEY_HOLD) |=>
      $stable(end_idx) && $stable(dwell))
    else $error("Designated key disturbed the cycle.");
  stop_key_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s and stop_key |=> state == OSS_IDLE ##1 !auto_cycle_function_out)
    else $error("Other key did not end the cycle.");
  auto_flag_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    auto_cycle_function_out == (state == OSS_RUN))
    else $error("Cycle flag disagrees with the cycle state.");
  single_step_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s and $past(state) == OSS_RUN and $changed(cur_idx) |->
      (cur_idx == $past(cur_idx) + 4'h1) || (cur_idx + 4'h1 == $past(cur_idx)))
    else $error("Cycle index jumped.");
  end_one_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s ##0 (end_idx == IDX_FIRST) |=> !setpoint_load_out && active_index_out == IDX_FIRST)
    else $error("Ending index one did not hold setpoint one.");
  sec_restart_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    step_s |=> sec_count == 9'h000)
    else $error("Dwell count did not restart.");
  sec_count_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s ##0 (tick && !dwell_done && next_state == OSS_RUN) |=>
      sec_count == $past(sec_count) + 9'h001)
    else $error("Dwell count missed a tick.");
  sec_idle_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    run_s ##0 !tick |=> $stable(sec_count))
    else $error("Dwell count moved without a tick.");
  tick_align_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    tick |-> tick_div == 25'h0000000)
    else $error("Second tick out of step with its divider.");
  tick_single_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    tick |=> !tick)
    else $error("Second tick wider than one cycle.");
  load_pulse_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    setpoint_load_out |=> !setpoint_load_out)
    else $error("Load pulse wider than one cycle.");
endmodule

/* File: verif/oss_panel_model.sv */
// Keypad and output stage model facing the setpoint sequencer.
`timescale 1ns/1ps
module oss_panel_model
  import oss_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               load_in,
  input  wire logic [VALUE_W-1:0] value_in,
  input  wire logic [3:0]         index_in,
  output logic                    key_valid_out = 1'b0,
  output logic [KEY_W-1:0]        key_code_out = 5'h00,
  output logic                    key_shift_out = 1'b0
);
  logic [VALUE_W-1:0] last_value;
  logic [3:0]         last_index;
  int                 loads = 0;
  // The output stage only takes a value on the load pulse.
  always @(posedge clk_in) begin
    if (load_in) begin
      last_value <= value_in;
      last_index <= index_in;
      loads <= loads + 1;
    end
  end
  // A released key bus shows inverted lines, so a stale code never passes for a press.
  task automatic press(input logic [KEY_W-1:0] code, input logic shift);
    @(posedge clk_in);
    key_valid_out <= 1'b1;
    key_code_out <= code;
    key_shift_out <= shift;
    @(posedge clk_in);
    key_valid_out <= 1'b0;
    key_code_out <= ~code;
    key_shift_out <= ~shift;
  endtask
endmodule

/* File: verif/output_setpoint_sequencer_bench.sv */
// Self-checking bench for the output setpoint sequencer.
`timescale 1ns/1ps
module output_setpoint_sequencer_bench;
  import oss_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [MODE_W-1:0]  mode = 5'h00;
  logic [VALUE_W-1:0] ent = 24'h000000;
  logic               kv, ks, ld, acf, rip;
  logic [KEY_W-1:0]   kc;
  logic [VALUE_W-1:0] sv;
  logic [3:0]         ai;
  logic [VALUE_W-1:0] bank [MODE_COUNT][1:9];
  logic [MODE_W-1:0]  mds [3];
  int                 n_errors = 0;
  int                 checks = 0;
  int                 cycles = 0;
  int                 n0;
  oss_sequencer dut_u (.core_clk_in(clk), .reset_n_in(rst_n), .key_valid_in(kv),
    .key_code_in(kc), .key_shift_in(ks), .out_mode_in(mode), .entered_value_in(ent),
    .setpoint_value_out(sv), .setpoint_load_out(ld), .active_index_out(ai),
    .auto_cycle_function_out(acf), .recall_index_prompt_out(rip));
  oss_panel_model panel_u (.clk_in(clk), .load_in(ld), .value_in(sv), .index_in(ai),
    .key_valid_out(kv), .key_code_out(kc), .key_shift_out(ks));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] loads_since();
    return 32'(panel_u.loads - n0);
  endfunction
  // Three spare cycles cover the load latency; the 1 ns step lets edge updates land.
  task automatic key(input logic [KEY_W-1:0] c, input logic s);
    panel_u.press(c, s);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic setin(input logic [MODE_W-1:0] md, input logic [VALUE_W-1:0] v);
    @(posedge clk);
    mode <= md;
    ent <= v;
    n0 = panel_u.loads;
  endtask
  task automatic store(input logic [MODE_W-1:0] md, input logic [3:0] s);
    setin(md, 24'($urandom));
    key(KEY_STORE, 1'b1);
    key({1'b0, s}, 1'b0);
    bank[md][s] = ent;
  endtask
  task automatic recall(input logic [MODE_W-1:0] md, input logic [3:0] s);
    setin(md, 24'($urandom));
    key(KEY_RECALL, 1'b1);
    cmp_val(32'(rip), 32'h1);
    key({1'b0, s}, 1'b0);
    cmp_val(loads_since(), 32'h1);
    cmp_val(32'(panel_u.last_value), 32'(bank[md][s]));
    cmp_val(32'(panel_u.last_index), 32'(s));
  endtask
  task automatic auto(input logic [3:0] e, input int d);
    setin(mds[0], ent);
    key(KEY_AUTO, 1'b1);
    key({1'b0, e}, 1'b0);
    key(5'(d / 100), 1'b0);
    key(5'(d / 10 % 10), 1'b0);
    key(5'(d % 10), 1'b0);
    key(KEY_ENTER, 1'b0);
  endtask
  initial begin
    void'($urandom(32'h681E628F));
    repeat (6) @(posedge clk);
    #1 cmp_val({ld, acf, rip, ai, sv}, 32'h0);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mds = '{5'($urandom % 30), 5'h00, 5'h1D};
    for (int k = 0; k < 3; k++) begin
      for (int s = 1; s < 10; s++) store(mds[k], 4'(s));
    end
    recall(5'h1D, 4'h9);
    for (int i = 0; i < 14; i++) recall(mds[$urandom % 3], 4'($urandom % 9 + 1));
    setin(mds[0], ent);
    key(KEY_RECALL, 1'b1);
    key(5'h04, 1'b1);
    cmp_val(loads_since(), 32'h0);
    key(KEY_ENTER, 1'b0);
    cmp_val(32'(rip), 32'h0);
    auto(4'h4, 4);
    cmp_val({loads_since(), acf}, 32'h0);
    auto(4'h4, 501);
    cmp_val({loads_since(), acf}, 32'h0);
    auto(4'h4, 999);
    cmp_val({loads_since(), acf}, 32'h0);
    auto(4'h9, 5);
    cmp_val({loads_since(), acf}, 32'h3);
    cmp_val(32'(panel_u.last_index), 32'h1);
    cmp_val(32'(panel_u.last_value), 32'(bank[mds[0]][1]));
    key(KEY_HOLD, 1'b0);
    cmp_val({loads_since(), acf}, 32'h3);
    key(5'h00, 1'b0);
    cmp_val(32'(acf), 32'h0);
    auto(4'h1, 500);
    cmp_val({loads_since(), acf, ai}, 32'h31);
    key(KEY_STORE, 1'b1);
    cmp_val(32'(acf), 32'h0);
    results();
  end
endmodule
